// File: logic/uart_core_consts.vh
// Purpose: constants of the asynchronous serial transmit/receive core
// Assumes: 8-bit register port with 3-bit address
// Notes:   offsets are register indices on the plain register port
`ifndef UART_CORE_CONSTS_VH
`define UART_CORE_CONSTS_VH

`define ADDR_MODE        3'h0
`define ADDR_CONTROL     3'h1
`define ADDR_BAUD_DIV    3'h2
`define ADDR_TX_BUFFER   3'h3
`define ADDR_TX_STATUS   3'h4
`define ADDR_RX_BUFFER   3'h5
`define ADDR_RX_ERR      3'h6

`define MODE_RESET       8'h01
`define CONTROL_RESET    8'h00
`define BAUD_DIV_RESET   8'h08
`define RX_BUFFER_RESET  8'hFF

`define MODE_POWER       7
`define MODE_TX_EN       6
`define MODE_RX_EN       5
`define MODE_PAR_HI      4
`define MODE_PAR_LO      3
`define MODE_LEN8        2
`define MODE_STOP2       1
`define MODE_MERGE       0

`define CTRL_MSB_FIRST   1
`define CTRL_INVERT      0

`define PAR_NONE         2'h0
`define PAR_ZERO         2'h1
`define PAR_ODD          2'h2
`define PAR_EVEN         2'h3

`define TXST_BUF_FULL    1
`define TXST_BUSY        0

`define ERR_PARITY       2
`define ERR_FRAMING      1
`define ERR_OVERRUN      0

`endif

// File: logic/async_serial_tx_rx_core.v
// Purpose: frame engine of an asynchronous serial unit, transmit and receive
// Assumes: one clock, register port with read data one cycle after the strobe
// Notes:   bit time is twice baud_divisor_reg cycles; start bit checked after baud_divisor_reg cycles
//          a second stop bit is ignored on receive
//
// Contract
// - frame: start, 7 or 8 data, optional parity, 1 or 2 stop bits from mode_reg
// - bit_order_select picks LSB-first or MSB-first for sending and receiving
// - out_invert_select drives serial_out true or inverted
// - even parity: sent bit makes ones even; odd total on receive is an error
// - odd parity: sent bit makes ones odd; even total on receive is an error
// - zero parity: parity sent as 0, never checked on receive
// - no parity: no parity bit sent or expected, no parity error
// - power then tx enable; then a tx_buffer write starts sending
// - tx_buffer moves to tx_shift_reg and shifts out with framing bits added
// - tx_done_irq pulses right after the last stop bit
// - transmitter idles after a frame until tx_buffer is written, or starts the next frame at once if tx_buffer already holds a byte
// - tx_buffer accepts a new byte once the previous frame starts shifting
// - status bit 1 buffer full, bit 0 shift busy
// - power then rx enable enables reception and sampling of serial_in
// - falling edge starts counter; low at divisor count means start bit
// - after stop bit buffer copy, except on overrun; rx_done_irq unless an error occurs with error_irq_merge clear
// - parity error does not abort; reported at end of frame
// - receiver checks only one stop bit
// - after error software reads error status then buffer, else overrun follows
// - reading rx_error_status clears all its flags
// - overrun when a frame ends before the previous buffer was read
// - error_irq_merge clear: separate error irq; set: errors on rx_done_irq
// - power off resets the unit, serial_out high, serial_in path high
`include "uart_core_consts.vh"
`timescale 1ns/1ps

module async_serial_tx_rx_core (
    input  wire       clock,        // 40 MHz clock
    input  wire       rst_n,        // asynchronous reset, active low
    input  wire [2:0] addr,         // register index
    input  wire [7:0] wdata,        // write data
    input  wire       wr_en,        // write strobe
    input  wire       rd_en,        // read strobe
    output reg  [7:0] rdata,        // read data, cycle after rd_en
    input  wire       serial_in,    // receive line
    output wire       serial_out,   // transmit line
    output reg        tx_done_irq,  // frame sent pulse
    output reg        rx_done_irq,  // frame received pulse
    output reg        rx_error_irq  // receive error pulse
);

    // one-hot frame states, shared by both engines
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_START = 5'h02;
    localparam [4:0] ST_DATA  = 5'h04;
    localparam [4:0] ST_PAR   = 5'h08;
    localparam [4:0] ST_STOP  = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg  [7:0] mode_ff;
    reg  [7:0] ctrl_ff;
    reg  [7:0] div_ff;
    reg  [7:0] tx_buf_ff;
    reg        buf_full_ff;
    reg        busy_ff;
    reg  [7:0] rx_buf_ff;
    reg        rx_full_ff;
    reg  [2:0] err_ff;
    reg  [7:0] nxt_rdata;

    wire       power     = mode_ff[`MODE_POWER];
    wire       tx_on     = power & mode_ff[`MODE_TX_EN];
    wire       rx_on     = power & mode_ff[`MODE_RX_EN];
    wire [1:0] par_mode  = {mode_ff[`MODE_PAR_HI], mode_ff[`MODE_PAR_LO]};
    wire       len8      = mode_ff[`MODE_LEN8];
    wire       msb_first = ctrl_ff[`CTRL_MSB_FIRST];
    wire [2:0] last_idx  = len8 ? 3'h7 : 3'h6;
    wire [8:0] bit_last  = {div_ff, 1'b0} - 9'h001;

    wire       wr_txb    = wr_en & (addr == `ADDR_TX_BUFFER) & tx_on & ~buf_full_ff;
    wire       rd_rxb    = rd_en & (addr == `ADDR_RX_BUFFER);
    wire       rd_err    = rd_en & (addr == `ADDR_RX_ERR);

    ////////////////////////////////////////////////////////////////////////
    // transmitter
    reg  [4:0] tx_st_ff;
    reg  [7:0] tx_sh_ff;
    reg  [8:0] tx_cnt_ff;
    reg  [2:0] tx_idx_ff;
    reg        tx_stop_ff;
    reg        tx_line_ff;

    wire       tx_tick   = (tx_cnt_ff == bit_last);
    wire [2:0] tx_nidx   = tx_idx_ff + 3'h1;
    wire [2:0] tx_pos    = msb_first ? (last_idx - tx_nidx) : tx_nidx;
    wire       tx_ones   = ^(tx_sh_ff & (len8 ? 8'hFF : 8'h7F));
    reg        tx_par;
    // with two stop bits tx_stop_ff marks that the first has passed
    wire       tx_end    = (tx_st_ff == ST_STOP) & tx_tick & (tx_stop_ff | ~mode_ff[`MODE_STOP2]);
    // a waiting byte loads at idle or right at the end of the last stop bit
    wire       tx_load   = buf_full_ff & (~busy_ff | tx_end);

    always @* begin
        case (par_mode)
            `PAR_EVEN: tx_par = tx_ones;
            `PAR_ODD:  tx_par = ~tx_ones;
            default:   tx_par = 1'b0;
        endcase
    end

    assign serial_out = power ? (tx_line_ff ^ ctrl_ff[`CTRL_INVERT]) : 1'b1;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_st_ff    <= ST_IDLE;
            tx_sh_ff    <= 8'h00;
            tx_cnt_ff   <= 9'h000;
            tx_idx_ff   <= 3'h0;
            tx_stop_ff  <= 1'b0;
            tx_line_ff  <= 1'b1;
            busy_ff     <= 1'b0;
            tx_done_irq <= 1'b0;
        end else if (!tx_on) begin
            tx_st_ff    <= ST_IDLE;
            tx_cnt_ff   <= 9'h000;
            tx_line_ff  <= 1'b1;
            busy_ff     <= 1'b0;
            tx_done_irq <= 1'b0;
        end else begin
            tx_done_irq <= tx_end;
            tx_cnt_ff   <= (tx_tick | tx_load) ? 9'h000 : tx_cnt_ff + 9'h001;
            if (tx_load) begin
                tx_sh_ff   <= tx_buf_ff;
                tx_st_ff   <= ST_START;
                tx_line_ff <= 1'b0;
                busy_ff    <= 1'b1;
            end else if (tx_tick) begin
                case (tx_st_ff)
                    ST_START: begin
                        tx_st_ff   <= ST_DATA;
                        tx_idx_ff  <= 3'h0;
                        tx_line_ff <= tx_sh_ff[msb_first ? last_idx : 3'h0];
                    end
                    ST_DATA: begin
                        // tx_idx_ff names the bit on the line, so 8 bits never wrap
                        if (tx_idx_ff == last_idx) begin
                            if (par_mode == `PAR_NONE) begin
                                tx_st_ff   <= ST_STOP;
                                tx_stop_ff <= 1'b0;
                                tx_line_ff <= 1'b1;
                            end else begin
                                tx_st_ff   <= ST_PAR;
                                tx_line_ff <= tx_par;
                            end
                        end else begin
                            tx_line_ff <= tx_sh_ff[tx_pos];
                            tx_idx_ff  <= tx_nidx;
                        end
                    end
                    ST_PAR: begin
                        tx_st_ff   <= ST_STOP;
                        tx_stop_ff <= 1'b0;
                        tx_line_ff <= 1'b1;
                    end
                    ST_STOP: begin
                        if (tx_end) begin
                            tx_st_ff <= ST_IDLE;
                            busy_ff  <= 1'b0;
                        end else begin
                            tx_stop_ff <= 1'b1;
                        end
                    end
                    default: begin
                        tx_line_ff <= 1'b1;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver
    reg  [4:0] rx_st_ff;
    reg  [7:0] rx_sh_ff;
    reg  [8:0] rx_cnt_ff;
    reg  [2:0] rx_idx_ff;
    reg        rx_par_ff;
    reg        rx_prev_ff;

    wire       rx_line   = power ? serial_in : 1'b1;
    // rx_prev_ff resets high, the idle level, so no false edge follows enable
    wire       rx_fall   = rx_prev_ff & ~rx_line;
    wire       rx_tick   = (rx_cnt_ff == bit_last);
    wire [2:0] rx_pos    = msb_first ? (last_idx - rx_idx_ff) : rx_idx_ff;
    wire       rx_ones   = ^(rx_sh_ff & (len8 ? 8'hFF : 8'h7F));
    reg        par_bad;
    // only the first stop bit is sampled; a second one passes as idle line
    wire       rx_end    = (rx_st_ff == ST_STOP) & rx_tick;
    wire       ovr_now   = rx_end & rx_full_ff;
    wire [2:0] err_now   = {rx_end & par_bad, rx_end & ~rx_line, ovr_now};

    always @* begin
        case (par_mode)
            `PAR_EVEN: par_bad = rx_ones ^ rx_par_ff;
            `PAR_ODD:  par_bad = ~(rx_ones ^ rx_par_ff);
            default:   par_bad = 1'b0;
        endcase
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_ff     <= ST_IDLE;
            rx_sh_ff     <= 8'h00;
            rx_cnt_ff    <= 9'h000;
            rx_idx_ff    <= 3'h0;
            rx_par_ff    <= 1'b0;
            rx_prev_ff   <= 1'b1;
            rx_done_irq  <= 1'b0;
            rx_error_irq <= 1'b0;
        end else if (!rx_on) begin
            rx_st_ff     <= ST_IDLE;
            rx_cnt_ff    <= 9'h000;
            rx_prev_ff   <= 1'b1;
            rx_done_irq  <= 1'b0;
            rx_error_irq <= 1'b0;
        end else begin
            rx_prev_ff   <= rx_line;
            // merge clear: an errored frame raises only the error pulse
            rx_done_irq  <= rx_end & (mode_ff[`MODE_MERGE] | ~(|err_now));
            rx_error_irq <= rx_end & ~mode_ff[`MODE_MERGE] & (|err_now);
            rx_cnt_ff    <= rx_tick ? 9'h000 : rx_cnt_ff + 9'h001;
            case (rx_st_ff)
                ST_IDLE: begin
                    rx_cnt_ff <= 9'h000;
                    if (rx_fall) begin
                        rx_st_ff <= ST_START;
                    end
                end
                ST_START: begin
                    // half a bit after the edge, so data bits are sampled mid-bit
                    if (rx_cnt_ff[7:0] == div_ff - 8'h01) begin
                        rx_cnt_ff <= 9'h000;
                        rx_idx_ff <= 3'h0;
                        rx_sh_ff  <= 8'h00;
                        rx_st_ff  <= rx_line ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rx_tick) begin
                        rx_sh_ff[rx_pos] <= rx_line;
                        rx_idx_ff        <= rx_idx_ff + 3'h1;
                        if (rx_idx_ff == last_idx) begin
                            rx_st_ff <= (par_mode == `PAR_NONE) ? ST_STOP : ST_PAR;
                        end
                    end
                end
                ST_PAR: begin
                    if (rx_tick) begin
                        rx_par_ff <= rx_line;
                        rx_st_ff  <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (rx_tick) begin
                        rx_st_ff <= ST_IDLE;
                    end
                end
                default: begin
                    rx_st_ff <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff     <= `MODE_RESET;
            ctrl_ff     <= `CONTROL_RESET;
            div_ff      <= `BAUD_DIV_RESET;
            tx_buf_ff   <= 8'h00;
            buf_full_ff <= 1'b0;
            rx_buf_ff   <= `RX_BUFFER_RESET;
            rx_full_ff  <= 1'b0;
            err_ff      <= 3'h0;
            rdata       <= 8'h00;
        end else begin
            if (wr_en && addr == `ADDR_MODE) begin
                mode_ff <= wdata;
            end
            if (wr_en && addr == `ADDR_CONTROL) begin
                ctrl_ff <= {6'h00, wdata[1:0]};
            end
            if (wr_en && addr == `ADDR_BAUD_DIV) begin
                div_ff <= wdata;
            end

            if (!power) begin
                buf_full_ff <= 1'b0;
                rx_buf_ff   <= `RX_BUFFER_RESET;
                rx_full_ff  <= 1'b0;
                err_ff      <= 3'h0;
            end else begin
                if (wr_txb) begin
                    tx_buf_ff   <= wdata;
                    buf_full_ff <= 1'b1;
                end else if (tx_load || !tx_on) begin
                    buf_full_ff <= 1'b0;
                end
                // on overrun the unread byte stays in the buffer
                if (rx_end && !ovr_now) begin
                    rx_buf_ff  <= rx_sh_ff;
                    rx_full_ff <= 1'b1;
                end else if (rd_rxb) begin
                    rx_full_ff <= 1'b0;
                end
                // an error in the cycle of the clearing read still lands
                err_ff <= (rd_err ? 3'h0 : err_ff) | err_now;
            end
            rdata <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux: data stand one cycle after the strobe, zero otherwise
    always @* begin
        nxt_rdata = 8'h00;
        if (rd_en) begin
            case (addr)
                `ADDR_MODE:      nxt_rdata = mode_ff;
                `ADDR_CONTROL:   nxt_rdata = ctrl_ff;
                `ADDR_BAUD_DIV:  nxt_rdata = div_ff;
                `ADDR_TX_STATUS: nxt_rdata = {6'h00, buf_full_ff, busy_ff};
                `ADDR_RX_BUFFER: nxt_rdata = rx_buf_ff;
                `ADDR_RX_ERR:    nxt_rdata = {5'h00, err_ff};
                default:         nxt_rdata = 8'h00;
            endcase
        end
    end

endmodule // async_serial_tx_rx_core

// File: tb/uart_core_sva.sv
// Purpose: port checker for the serial transmit/receive core
// Assumes: bound to every instance of the core
// Notes:   mirrors mode and control writes to know power, merge and invert
`timescale 1ns/1ps
module uart_core_sva (
    input wire       clock,        // unit clock
    input wire       rst_n,        // async reset, active low
    input wire [2:0] addr,         // register index
    input wire [7:0] wdata,        // write data
    input wire       wr_en,        // write strobe
    input wire       rd_en,        // read strobe
    input wire [7:0] rdata,        // read data
    input wire       serial_in,    // receive line
    input wire       serial_out,   // transmit line
    input wire       tx_done_irq,  // frame sent
    input wire       rx_done_irq,  // frame received
    input wire       rx_error_irq  // receive error
);
    reg [7:0] mode_ff;
    reg       inv_ff;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= 8'h01;
            inv_ff  <= 1'b0;
        end else if (wr_en && addr == 3'h0) mode_ff <= wdata;
        else if (wr_en && addr == 3'h1) inv_ff <= wdata[0];
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    property p_status_bits; rd_en && addr == 3'h4 |=> rdata[7:2] == 6'h00; endproperty
    a_status_bits: assert property (p_status_bits) else $error("status upper bits set");
    property p_err_clear;
        (rd_en && addr == 3'h6) ##1 (rd_en && addr == 3'h6 && !rx_done_irq && !rx_error_irq)
        |=> rdata == 8'h00 || rx_done_irq || rx_error_irq;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error flags kept after read");
    property p_tx_pulse; tx_done_irq |=> !tx_done_irq; endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("tx done longer than one cycle");
    property p_tx_stop; tx_done_irq |-> $past(serial_out) == !inv_ff; endproperty
    a_tx_stop: assert property (p_tx_stop) else $error("tx done not after stop bit");
    property p_merge; rx_error_irq |-> !mode_ff[0]; endproperty
    a_merge: assert property (p_merge) else $error("error irq while merged");
    property p_irq_excl; !(rx_done_irq && rx_error_irq); endproperty
    a_irq_excl: assert property (p_irq_excl) else $error("both receive irqs at once");
    property p_rx_pulse; rx_done_irq |=> !rx_done_irq; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx done longer than one cycle");
    property p_off_line; !mode_ff[7] |-> serial_out; endproperty
    a_off_line: assert property (p_off_line) else $error("line low while unpowered");
    property p_off_quiet;
        !mode_ff[7] && !$past(mode_ff[7]) && !$past(mode_ff[7], 2) |-> !(tx_done_irq || rx_done_irq || rx_error_irq);
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("irq while unpowered");
endmodule // uart_core_sva

bind async_serial_tx_rx_core uart_core_sva chk_u (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .serial_in(serial_in), .serial_out(serial_out),
    .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq));

// File: tb/serial_node.sv
// Purpose: remote serial node on the far side of both lines
// Assumes: one bit lasts BIT clocks of the unit
// Notes:   the unit's receive line idles high as with a pull-up
`include "uart_core_consts.vh"
`timescale 1ns/1ps
module serial_node #(
    parameter int BIT = 4  // clocks per bit
) (
    input  wire  clock,    // unit clock
    input  wire  line_in,  // unit transmit line
    output logic line_out  // unit receive line
);
    initial line_out = 1'b1;
    function automatic logic par(input [7:0] d, input int n, input [1:0] pm);
        logic x;
        x = ^(n == 8 ? d : {1'b0, d[6:0]});
        return pm == `PAR_EVEN ? x : (pm == `PAR_ODD ? ~x : 1'b0);
    endfunction
    task automatic put(input logic b);
        @(posedge clock);
        line_out <= b;
        repeat (BIT - 1) @(posedge clock);
    endtask
    // se pulls the first stop bit low
    task automatic send(input [7:0] d, input int n, input [1:0] pm, input st2, msb, pe, se);
        put(1'b0);
        for (int i = 0; i < n; i++) put(msb ? d[n - 1 - i] : d[i]);
        if (pm != `PAR_NONE) put(par(d, n, pm) ^ pe);
        put(!se);
        if (st2) put(1'b1);
        @(posedge clock);
        line_out <= 1'b1;
    endtask
    task automatic recv(input int n, input hp, msb, inv, output [7:0] d, output p, output ok);
        int k;
        d = 8'h00;
        p = 1'b0;
        for (k = 0; k < 4000 && line_in !== inv; k++) @(posedge clock);
        ok = k < 4000;
        repeat (BIT / 2) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            repeat (BIT) @(posedge clock);
            if (msb) d = {d[6:0], line_in ^ inv};
            else d[i] = line_in ^ inv;
        end
        if (hp) begin
            repeat (BIT) @(posedge clock);
            p = line_in ^ inv;
        end
        repeat (BIT) @(posedge clock);
        ok = ok && ((line_in ^ inv) === 1'b1);
    endtask
endmodule // serial_node

// File: tb/async_serial_tx_rx_core_tb.sv
// Purpose: self-checking bench for the serial transmit/receive core
// Assumes: baud divisor 2, so one bit lasts 4 clocks
// Notes:   the node model plays the far end of both lines
`timescale 1ns/1ps
module async_serial_tx_rx_core_tb;
    localparam int BIT = 4;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic [2:0] addr  = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    wire  [7:0] rdata;
    wire        serial_in, serial_out, tx_done_irq, rx_done_irq, rx_error_irq;
    int         errors = 0;
    int         cmp_count = 0;
    logic [7:0] n_txd = 8'h00, n_rxd = 8'h00, n_rxe = 8'h00, v, t0, r0, e0;
    logic       p;
    logic [7:0] rst_tab [8] = '{8'h01, 8'h00, 8'h08, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        n_txd <= n_txd + {7'h00, tx_done_irq};
        n_rxd <= n_rxd + {7'h00, rx_done_irq};
        n_rxe <= n_rxe + {7'h00, rx_error_irq};
    end
    async_serial_tx_rx_core dut_u (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .serial_in(serial_in), .serial_out(serial_out),
        .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq));
    serial_node #(.BIT(BIT)) node_u (.clock(clock), .line_in(serial_out), .line_out(serial_in));
    ////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input [7:0] got, input [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input [2:0] a, input [7:0] d);
        @(posedge clock);
        addr <= a; wdata <= d; wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input [2:0] a, output [7:0] d);
        @(posedge clock);
        addr <= a; rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic get(input int n, input hp, msb, inv, output [7:0] d);
        logic ok;
        node_u.recv(n, hp, msb, inv, d, p, ok);
        chk(8'(ok), 8'h01);
        if (!ok) test_done;
    endtask
    task automatic tx_case(input [7:0] m, input [7:0] c, input [7:0] d);
        int n;
        n = m[2] ? 8 : 7;
        wr(3'h1, c); wr(3'h0, m); t0 = n_txd;
        wr(3'h3, d);
        get(n, m[4:3] != 2'h0, c[1], c[0], v);
        chk(v, n == 8 ? d : {1'b0, d[6:0]});
        if (m[4:3] != 2'h0) chk(8'(p), 8'(node_u.par(d, n, m[4:3])));
        repeat (BIT / 2 + (m[1] ? BIT : 0) - 1) @(posedge clock);
        chk(n_txd, t0);
        repeat (4) @(posedge clock);
        chk(n_txd, t0 + 8'h01);
        chk(8'(serial_out), 8'(!c[0]));
        rd(3'h4, v); chk(v, 8'h00);
    endtask
    task automatic rx_case(input [7:0] m, input [7:0] c, input [7:0] d, input pe, se, input [7:0] ee);
        int n;
        n = m[2] ? 8 : 7;
        wr(3'h1, c); wr(3'h0, m); r0 = n_rxd; e0 = n_rxe;
        node_u.send(d, n, m[4:3], m[1], c[1], pe, se);
        repeat (BIT) @(posedge clock);
        chk(n_rxd - r0, 8'(ee == 8'h00 || m[0]));
        chk(n_rxe - e0, 8'(ee != 8'h00 && !m[0]));
        rd(3'h6, v); chk(v, ee);
        rd(3'h5, v); chk(v & (n == 8 ? 8'hFF : 8'h7F), n == 8 ? d : {1'b0, d[6:0]});
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0], v); chk(v, rst_tab[i]);
        end
        wr(3'h2, 8'h02); rd(3'h2, v); chk(v, 8'h02);
        wr(3'h1, 8'hFF); rd(3'h1, v); chk(v, 8'h03);
        wr(3'h4, 8'hFF); rd(3'h4, v); chk(v, 8'h00);
        wr(3'h0, 8'h80);
        wr(3'h0, 8'hA4); wr(3'h3, 8'h11);
        repeat (BIT * 3) @(posedge clock);
        rd(3'h4, v); chk(v, 8'h00);
        tx_case(8'hFC, 8'h00, 8'h55); tx_case(8'hFC, 8'h02, 8'h55); tx_case(8'hFC, 8'h03, 8'h55);
        tx_case(8'hFC, 8'h00, 8'h07); tx_case(8'hF2, 8'h00, 8'h36); tx_case(8'hE4, 8'h00, 8'h87);
        tx_case(8'hEC, 8'h00, 8'hA5); tx_case(8'hF6, 8'h02, 8'h4B);
        t0 = n_txd;
        wr(3'h3, 8'hA1);
        fork
            begin
                get(8, 1'b1, 1'b1, 1'b0, r0); chk(r0, 8'hA1);
                get(8, 1'b1, 1'b1, 1'b0, r0); chk(r0, 8'hB2);
            end
            begin
                rd(3'h4, e0); chk(e0, 8'h01);
                wr(3'h3, 8'hB2); rd(3'h4, e0); chk(e0, 8'h03);
                wr(3'h3, 8'hC3);
            end
        join
        repeat (BIT * 2) @(posedge clock);
        chk(n_txd, t0 + 8'h02);
        repeat (BIT * 12) @(posedge clock);
        chk(n_txd, t0 + 8'h02);
        rd(3'h4, v); chk(v, 8'h00);
        rx_case(8'hFC, 8'h00, 8'h5A, 1'b0, 1'b0, 8'h00); rx_case(8'hFC, 8'h00, 8'h5B, 1'b1, 1'b0, 8'h04);
        rx_case(8'hF4, 8'h00, 8'h96, 1'b1, 1'b0, 8'h04); rx_case(8'hF4, 8'h00, 8'h97, 1'b0, 1'b0, 8'h00);
        rx_case(8'hEC, 8'h00, 8'h3D, 1'b1, 1'b0, 8'h00); rx_case(8'hE4, 8'h00, 8'h81, 1'b0, 1'b0, 8'h00);
        rx_case(8'hFC, 8'h02, 8'hC1, 1'b0, 1'b0, 8'h00); rx_case(8'hFD, 8'h00, 8'h22, 1'b1, 1'b0, 8'h04);
        rx_case(8'hF2, 8'h02, 8'h36, 1'b0, 1'b0, 8'h00); rx_case(8'hFC, 8'h00, 8'h6E, 1'b0, 1'b1, 8'h02);
        wr(3'h0, 8'hFE); r0 = n_rxd; e0 = n_rxe;
        node_u.send(8'h3C, 8, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0);
        node_u.send(8'hC3, 8, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0);
        repeat (BIT) @(posedge clock);
        chk(n_rxd - r0, 8'h01);
        chk(n_rxe - e0, 8'h01);
        @(posedge clock); addr <= 3'h6; rd_en <= 1'b1;
        @(posedge clock); #1 chk(rdata, 8'h01);
        @(posedge clock); rd_en <= 1'b0; #1 chk(rdata, 8'h00);
        rd(3'h5, v); chk(v, 8'h3C);
        node_u.send(8'h5A, 8, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0);
        wr(3'h1, 8'h01); wr(3'h0, 8'h01);
        rd(3'h5, v); chk(v, 8'hFF);
        chk(8'(serial_out), 8'h01);
        test_done;
    end
endmodule // async_serial_tx_rx_core_tb
